// File: verilog/rbt_pkg.sv
`default_nettype none
package rbt_pkg;
  // data path width
  localparam int unsigned DATA_W = 8;
  // wishbone register offsets (byte addresses)
  localparam logic [3:0] OFF_CAPTURE = 4'h0;
  localparam logic [3:0] OFF_CONTROL = 4'h4;
  localparam logic [3:0] OFF_SWCAP   = 4'h8;
  // field positions
  localparam int unsigned CAP_A_LSB     = 0;
  localparam int unsigned CAP_B_LSB     = 8;
  localparam int unsigned CTL_AB_EN     = 0;
  localparam int unsigned CTL_BA_EN_N   = 1;
  localparam int unsigned CTL_AB_SEL    = 2;
  localparam int unsigned CTL_BA_SEL    = 3;
  localparam int unsigned CTL_A_CLK     = 4;
  localparam int unsigned CTL_B_CLK     = 5;
  localparam int unsigned SWCAP_A       = 0;
  localparam int unsigned SWCAP_B       = 1;
  // values after reset
  localparam logic [7:0]  CAP_RESET     = 8'h00;
  localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;
endpackage
`default_nettype wire

// File: verilog/rbt_transceiver.sv
// Implementation choices: the Wishbone register port and the register addresses.
`default_nettype none
// Notes on behaviour
// R1: rising edge of each capture clock loads its port into its register, always.
// R2: select low passes live opposite-port data, high passes stored register value.
// R3: switching select never glitches driven outputs; outputs come from flip-flops.
// R4: a-to-b enable high drives port b; b-to-a enable low drives port a.
// R5: a-to-b enabled, select low: port b shows live port a.
// R6: a-to-b enabled, select high: port b shows a-side register.
// R7: b-to-a enabled, select low: port a shows live port b.
// R8: b-to-a enabled, select high: port a shows b-side register.
// R9: both enabled, both selects high: each port driven from opposite register.
// R10: both enabled live: each output reinforces its own input, holding last state.
// R11: with select low, both capture clocks may rise together, loading same data.
// R12: with select high, outside logic must stagger the two capture edges.
// R13: eight-bit ports and registers; capture edges sampled on the system clock.
module rbt_transceiver #(
  parameter int unsigned WIDTH = rbt_pkg::DATA_W
) (
  // system
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // port a lines
  input  wire logic [WIDTH-1:0] port_a_lines_i,
  output logic      [WIDTH-1:0] port_a_lines_o,
  output logic                  port_a_lines_oe_n_o,
  // port b lines
  input  wire logic [WIDTH-1:0] port_b_lines_i,
  output logic      [WIDTH-1:0] port_b_lines_o,
  output logic                  port_b_lines_oe_n_o,
  // bus control
  input  wire logic             a_to_b_drive_enable_i,
  input  wire logic             b_to_a_drive_enable_n_i,
  input  wire logic             a_to_b_source_select_i,
  input  wire logic             b_to_a_source_select_i,
  input  wire logic             a_capture_clock_i,
  input  wire logic             b_capture_clock_i,
  // wishbone slave
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [3:0]       adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      dat_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o
);

  // elaboration check: the data path is fixed at eight bits
  if (WIDTH != 8) begin : g_width_check
    $error("rbt_transceiver: WIDTH must be 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture clock edge detection

  logic             a_clk_q, b_clk_q;
  logic             a_rise, b_rise;
  logic [WIDTH-1:0] a_reg_q, b_reg_q;
  logic             sw_cap_a, sw_cap_b;

  // previous level of each capture clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_clk_q <= 1'b0;
      b_clk_q <= 1'b0;
    end else begin
      a_clk_q <= a_capture_clock_i;
      b_clk_q <= b_capture_clock_i;
    end
  end

  // rising transitions seen in the system clock domain
  assign a_rise = a_capture_clock_i & ~a_clk_q; // R13
  assign b_rise = b_capture_clock_i & ~b_clk_q; // R13

  ////////////////////////////////////////////////////////////////////////////
  // capture registers

  // load regardless of enables and selects
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_reg_q <= rbt_pkg::CAP_RESET;
      b_reg_q <= rbt_pkg::CAP_RESET;
    end else begin
      if (a_rise || sw_cap_a) a_reg_q <= port_a_lines_i; // R1 R11
      if (b_rise || sw_cap_b) b_reg_q <= port_b_lines_i; // R1 R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output path

  logic [WIDTH-1:0] b_src, a_src;

  // source selection: low live, high stored
  assign b_src = a_to_b_source_select_i ? a_reg_q : port_a_lines_i; // R2 R5 R6
  assign a_src = b_to_a_source_select_i ? b_reg_q : port_b_lines_i; // R2 R7 R8

  // registered data and enables, so a select change cannot glitch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_b_lines_o      <= '0;
      port_a_lines_o      <= '0;
      port_b_lines_oe_n_o <= 1'b1;
      port_a_lines_oe_n_o <= 1'b1;
    end else begin
      port_b_lines_o      <= b_src; // R3 R9 R10
      port_a_lines_o      <= a_src; // R3 R9 R10
      port_b_lines_oe_n_o <= ~a_to_b_drive_enable_i; // R4
      port_a_lines_oe_n_o <= b_to_a_drive_enable_n_i; // R4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  logic        req, wr_hit;
  logic [31:0] rd_mux;

  assign req      = cyc_i & stb_i & ~ack_o;
  assign wr_hit   = req & we_i & sel_i[0] & (adr_i == rbt_pkg::OFF_SWCAP);
  assign sw_cap_a = wr_hit & dat_i[rbt_pkg::SWCAP_A];
  assign sw_cap_b = wr_hit & dat_i[rbt_pkg::SWCAP_B];

  // read decode, unmapped reads as zero
  always_comb begin
    rd_mux = rbt_pkg::RDATA_RESET;
    unique case (adr_i)
      rbt_pkg::OFF_CAPTURE: begin
        rd_mux[rbt_pkg::CAP_A_LSB +: 8] = a_reg_q;
        rd_mux[rbt_pkg::CAP_B_LSB +: 8] = b_reg_q;
      end
      rbt_pkg::OFF_CONTROL: begin
        rd_mux[rbt_pkg::CTL_AB_EN]   = a_to_b_drive_enable_i;
        rd_mux[rbt_pkg::CTL_BA_EN_N] = b_to_a_drive_enable_n_i;
        rd_mux[rbt_pkg::CTL_AB_SEL]  = a_to_b_source_select_i;
        rd_mux[rbt_pkg::CTL_BA_SEL]  = b_to_a_source_select_i;
        rd_mux[rbt_pkg::CTL_A_CLK]   = a_capture_clock_i;
        rd_mux[rbt_pkg::CTL_B_CLK]   = b_capture_clock_i;
      end
      default: rd_mux = rbt_pkg::RDATA_RESET;
    endcase
  end

  // one-cycle ack, read data registered with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= rbt_pkg::RDATA_RESET;
    end else begin
      ack_o <= req;
      if (req && !we_i) dat_o <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  a_a_capture_load: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    a_rise |=> a_reg_q == $past(port_a_lines_i))
    else $error("a-side register missed a capture edge");

  a_b_capture_load: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    b_rise |=> b_reg_q == $past(port_b_lines_i))
    else $error("b-side register missed a capture edge");

  a_reg_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    (!a_rise && !sw_cap_a) |=> $stable(a_reg_q))
    else $error("a-side register changed without an edge");

  a_b_drive_en: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    ##1 port_b_lines_oe_n_o == !$past(a_to_b_drive_enable_i))
    else $error("port b enable does not follow a-to-b enable");

  a_a_drive_en: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    ##1 port_a_lines_oe_n_o == $past(b_to_a_drive_enable_n_i))
    else $error("port a enable does not follow b-to-a enable");

  a_b_live: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    (a_to_b_drive_enable_i && !a_to_b_source_select_i)
      |=> !port_b_lines_oe_n_o && port_b_lines_o == $past(port_a_lines_i))
    else $error("port b not driven with live port a");

  a_b_stored: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    (a_to_b_drive_enable_i && a_to_b_source_select_i)
      |=> port_b_lines_o == $past(a_reg_q))
    else $error("port b not driven with a-side register");

  a_a_live: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    (!b_to_a_drive_enable_n_i && !b_to_a_source_select_i)
      |=> !port_a_lines_oe_n_o && port_a_lines_o == $past(port_b_lines_i))
    else $error("port a not driven with live port b");

  a_a_stored: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    (!b_to_a_drive_enable_n_i && b_to_a_source_select_i)
      |=> port_a_lines_o == $past(b_reg_q))
    else $error("port a not driven with b-side register");

  a_both_stored: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    (a_to_b_drive_enable_i && !b_to_a_drive_enable_n_i
     && a_to_b_source_select_i && b_to_a_source_select_i)
      |=> !port_a_lines_oe_n_o && !port_b_lines_oe_n_o
          && port_a_lines_o == $past(b_reg_q) && port_b_lines_o == $past(a_reg_q))
    else $error("dual stored transfer wrong");

  a_joint_store: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    (a_rise && b_rise && port_a_lines_i == port_b_lines_i)
      |=> a_reg_q == b_reg_q)
    else $error("simultaneous capture loaded different data");

  a_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
    else $error("wishbone ack not a single cycle pulse");

  ////////////////////////////////////////////////////////////////////////////
  // register path, select switching and readback checks

  // b-side register holds between capture events
  a_b_reg_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    (!b_rise && !sw_cap_b) |=> $stable(b_reg_q))
    else $error("b-side register changed without an edge");

  // port b select change lands cleanly on the next registered value
  a_b_sel_clean: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    $changed(a_to_b_source_select_i)
      |=> port_b_lines_o == ($past(a_to_b_source_select_i) ? $past(a_reg_q)
                                                            : $past(port_a_lines_i)))
    else $error("port b wrong across a select change");

  // port a select change lands cleanly on the next registered value
  a_a_sel_clean: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    $changed(b_to_a_source_select_i)
      |=> port_a_lines_o == ($past(b_to_a_source_select_i) ? $past(b_reg_q)
                                                            : $past(port_b_lines_i)))
    else $error("port a wrong across a select change");

  // both directions live: each output follows the other port's level
  a_loop_both: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    (a_to_b_drive_enable_i && !b_to_a_drive_enable_n_i
     && !a_to_b_source_select_i && !b_to_a_source_select_i)
      |=> port_b_lines_o == $past(port_a_lines_i)
          && port_a_lines_o == $past(port_b_lines_i))
    else $error("live loop does not reinforce both ports");

  // disabled port b is released while its data keeps tracking
  a_b_released: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    (!a_to_b_drive_enable_i && !a_to_b_source_select_i)
      |=> port_b_lines_oe_n_o && port_b_lines_o == $past(port_a_lines_i))
    else $error("port b not released while disabled");

  // disabled port a is released while its data keeps tracking
  a_a_released: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    (b_to_a_drive_enable_n_i && !b_to_a_source_select_i)
      |=> port_a_lines_oe_n_o && port_a_lines_o == $past(port_b_lines_i))
    else $error("port a not released while disabled");

  // software strobe loads the a-side register
  a_sw_cap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sw_cap_a |=> a_reg_q == $past(port_a_lines_i))
    else $error("software capture missed the a-side register");

  // software strobe loads the b-side register
  a_sw_cap_b: assert property (@(posedge clk_i) disable iff (rst_i)
    sw_cap_b |=> b_reg_q == $past(port_b_lines_i))
    else $error("software capture missed the b-side register");

  // capture readback shows both registers with the ack
  a_wb_cap_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && adr_i == rbt_pkg::OFF_CAPTURE)
      |=> ack_o && dat_o == {16'h0000, $past(b_reg_q), $past(a_reg_q)})
    else $error("capture readback wrong");

  // control readback reflects the live control levels
  a_wb_ctl_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && adr_i == rbt_pkg::OFF_CONTROL)
      |=> dat_o == {26'h0, $past(b_capture_clock_i), $past(a_capture_clock_i),
                    $past(b_to_a_source_select_i), $past(a_to_b_source_select_i),
                    $past(b_to_a_drive_enable_n_i), $past(a_to_b_drive_enable_i)})
    else $error("control readback wrong");

  // strobe and unmapped places read as zero
  a_wb_blank_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && adr_i != rbt_pkg::OFF_CAPTURE
     && adr_i != rbt_pkg::OFF_CONTROL)
      |=> dat_o == rbt_pkg::RDATA_RESET)
    else $error("unmapped readback not zero");

  // both ports driven from the stored registers at once
  c_both_stored: cover property (@(posedge clk_i) disable iff (rst_i) // R9
    a_to_b_drive_enable_i && !b_to_a_drive_enable_n_i
    && a_to_b_source_select_i && b_to_a_source_select_i);

  c_live_both: cover property (@(posedge clk_i) disable iff (rst_i) // R10
    a_to_b_drive_enable_i && !b_to_a_drive_enable_n_i
    && !a_to_b_source_select_i && !b_to_a_source_select_i);

  c_joint_edges: cover property (@(posedge clk_i) disable iff (rst_i) // R11
    a_rise && b_rise);

  c_sel_switch: cover property (@(posedge clk_i) disable iff (rst_i) // R3
    a_to_b_drive_enable_i && $changed(a_to_b_source_select_i));

endmodule
`default_nettype wire

// File: test/rbt_bus_partner.sv
`default_nettype none
module rbt_bus_partner (
  // device drive
  input  wire logic [7:0] dev_a_i,
  input  wire logic       dev_a_oe_n_i,
  input  wire logic [7:0] dev_b_i,
  input  wire logic       dev_b_oe_n_i,
  // far-side data
  input  wire logic [7:0] far_a_i,
  input  wire logic [7:0] far_b_i,
  // resolved bus levels
  output logic      [7:0] bus_a_o,
  output logic      [7:0] bus_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // far side backs off while the device drives, so no contention
  assign bus_a_o = dev_a_oe_n_i ? far_a_i : dev_a_i;
  assign bus_b_o = dev_b_oe_n_i ? far_b_i : dev_b_i;
endmodule
`default_nettype wire

// File: test/registered_bidir_transceiver_tb_top.sv
`default_nettype none
module registered_bidir_transceiver_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, ab_en, ba_en_n, ab_sel, ba_sel, ca, cb, pa, pb;
  logic        cyc, stb, we, ack, aoe, boe, run;
  logic [7:0]  fa, fb, ao, bo, bus_a, bus_b, m_a, m_b, v;
  logic [8:0]  ea, eb;
  logic [3:0]  adr, sel;
  logic [31:0] wd, rd, r;
  int          bad_count, samples_checked;
  rbt_transceiver u_rbt_transceiver (.clk_i(clk_i), .rst_i(rst_i),
    .port_a_lines_i(bus_a), .port_a_lines_o(ao), .port_a_lines_oe_n_o(aoe),
    .port_b_lines_i(bus_b), .port_b_lines_o(bo), .port_b_lines_oe_n_o(boe),
    .a_to_b_drive_enable_i(ab_en), .b_to_a_drive_enable_n_i(ba_en_n),
    .a_to_b_source_select_i(ab_sel), .b_to_a_source_select_i(ba_sel),
    .a_capture_clock_i(ca), .b_capture_clock_i(cb), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rd), .ack_o(ack));
  rbt_bus_partner u_rbt_bus_partner (.dev_a_i(ao), .dev_a_oe_n_i(aoe),
    .dev_b_i(bo), .dev_b_oe_n_i(boe), .far_a_i(fa), .far_b_i(fb),
    .bus_a_o(bus_a), .bus_b_o(bus_b));
  ////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk_pin(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t port got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t word got %h exp %h", $time, got, exp);
    end
  endtask
  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    // ack must be gone one cycle later
    @(posedge clk_i);
    chk_word({31'h0, ack}, 32'h0);
  endtask
  // expected port drive: release level, then stored or live source
  function automatic logic [8:0] exp_drive(input logic oe_n, input logic stored,
                                           input logic [7:0] reg_v,
                                           input logic [7:0] live);
    return {oe_n, stored ? reg_v : live};
  endfunction
  // random controls, data and capture clocks
  task automatic step();
    logic [31:0] x;
    x = $urandom;
    @(posedge clk_i);
    fa <= x[7:0];
    fb <= x[15:8];
    {ab_en, ba_en_n, ab_sel, ba_sel} <= x[19:16];
    ca <= x[20];
    cb <= x[21] & !(x[20] & (x[17] | x[16]));
  endtask
  task automatic results();
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // reference model, outputs one edge behind the levels they follow
  always @(posedge clk_i) begin
    eb = exp_drive(!ab_en, ab_sel, m_a, bus_a);
    ea = exp_drive(ba_en_n, ba_sel, m_b, bus_b);
    if (ca && !pa) m_a = bus_a;
    if (cb && !pb) m_b = bus_b;
    {pa, pb} = {ca, cb};
    if (rst_i) {m_a, m_b, pa, pb} = 18'h0;
    #1;
    if (run) begin
      chk_pin({boe, bo}, eb);
      chk_pin({aoe, ao}, ea);
    end
  end
  // watchdog
  initial begin
    #50us;
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(50392));
    {rst_i, run, ab_en, ab_sel, ba_sel, ca, cb, cyc, stb, we} <= 10'h200;
    {ba_en_n, fa, fb, adr, sel, wd} <= {1'b1, 16'h5aa5, 4'h0, 4'hf, 32'h0};
    {bad_count, samples_checked} = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk_pin({aoe, ao}, 9'h100);
    chk_pin({boe, bo}, 9'h100);
    @(posedge clk_i);
    run = 1'b1;
    wb(1'b0, 4'h0, 32'h0);
    chk_word(r, 32'h0);
    repeat (300) step();
    // live a to b, both capture clocks rise together
    v = 8'($urandom);
    @(posedge clk_i);
    {ab_en, ba_en_n, ab_sel, ba_sel, ca, cb, fa} <= {6'b110000, v};
    repeat (3) @(posedge clk_i);
    {ca, cb} <= 2'b11;
    repeat (2) @(posedge clk_i);
    wb(1'b0, 4'h0, 32'h0);
    chk_word(r, {16'h0, v, v});
    // both live, far side changes but the loop holds
    @(posedge clk_i);
    {ba_en_n, ca, cb} <= 3'b000;
    repeat (2) @(posedge clk_i);
    {fa, fb} <= {~v, ~v};
    repeat (4) @(posedge clk_i);
    #1;
    chk_pin({1'b0, bus_a}, {1'b0, v});
    chk_pin({1'b0, bus_b}, {1'b0, v});
    repeat (4) begin
      step();
      wb(1'b0, 4'h4, 32'h0);
      chk_word(r, {26'h0, cb, ca, ba_sel, ab_sel, ba_en_n, ab_en});
    end
    // unmapped place and write-only strobe read back zero
    wb(1'b1, 4'hc, 32'hffff_ffff);
    wb(1'b0, 4'hc, 32'h0);
    chk_word(r, 32'h0);
    wb(1'b0, 4'h8, 32'h0);
    chk_word(r, 32'h0);
    // software capture of both ports
    run = 1'b0;
    v = 8'($urandom);
    @(posedge clk_i);
    {ab_en, ba_en_n, ca, cb, fa, fb} <= {4'b0100, v, ~v};
    wb(1'b1, 4'h8, 32'h3);
    wb(1'b0, 4'h0, 32'h0);
    chk_word(r, {16'h0, ~v, v});
    results();
  end
endmodule
`default_nettype wire
